// ---- rtl/shift_subtract_alu.sv ----
/*
 * Integer execution slice: right shifts, trapping word subtract and the
 * issue-break no-operation. One instruction per cycle, result one
 * cycle later on registered write-back and status outputs.
 * Assumes the register file supplies both source values in the same
 * cycle as the instruction, and drops nothing we do not claim.
 */
`timescale 1ns/1ps
`include "ssa_map.svh"

module shift_subtract_alu import ssa_pkg::*; #(
	parameter bit SUPERSCALAR = 1'b1,
	parameter bit RELEASE6 = 1'b0
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Issued instruction and its operands
	input wire logic valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] src_a_i,
	input wire logic [31:0] src_b_i,
	// Write-back to the register file
	output logic wb_en_o,
	output logic [4:0] wb_idx_o,
	output logic [31:0] wb_data_o,
	// Exceptions and issue control
	output logic ovf_trap_o,
	output logic unclaimed_o,
	output logic slot_used_o,
	output logic break_group_o,
	output logic issue_alone_o,
	output logic ready_o
);

	// Instruction fields
	logic [5:0] opc_f;
	logic [5:0] func_f;
	reg_idx_t src_a_f;
	reg_idx_t dest_f;
	reg_idx_t amt_f;
	op_e op;

	assign opc_f = instr_i[`SSA_OPC_HI:`SSA_OPC_LO];
	assign func_f = instr_i[`SSA_FUNC_HI:`SSA_FUNC_LO];
	assign src_a_f = instr_i[`SSA_SRC_A_HI:`SSA_SRC_A_LO];
	assign dest_f = instr_i[`SSA_DEST_HI:`SSA_DEST_LO];
	assign amt_f = instr_i[`SSA_AMT_HI:`SSA_AMT_LO];

	// Decode; anything with stray bits in a must-be-zero field is left
	// unclaimed so another slice or the reserved trap can take it
	always_comb begin
		op = op_none;
		if (instr_i == `SSA_BREAK_WORD) begin
			op = op_issue_break;
		end else if (opc_f == `SSA_OPC_ZERO) begin
			case (func_f)
				`SSA_FN_ARITH_IMM: begin
					if (src_a_f == `SSA_REG_ZERO)
						op = op_arith_imm;
				end
				`SSA_FN_ARITH_VAR: begin
					if (amt_f == `SSA_REG_ZERO)
						op = op_arith_var;
				end
				`SSA_FN_LOGIC_IMM: begin
					if (src_a_f == `SSA_REG_ZERO)
						op = op_logic_imm;
				end
				`SSA_FN_LOGIC_VAR: begin
					if (amt_f == `SSA_REG_ZERO)
						op = op_logic_var;
				end
				`SSA_FN_SUB_TRAP: begin
					if (amt_f == `SSA_REG_ZERO)
						op = op_sub_trap;
				end
				default: op = op_none;
			endcase
		end
	end

	// Shared shifter: one instance serves all four shift forms
	logic [4:0] shift_amt;
	logic shift_arith;
	word_t shift_res;

	// variable counts use the low five source bits
	assign shift_amt = (op == op_arith_var || op == op_logic_var) ?
		src_a_i[4:0] : amt_f;
	assign shift_arith = (op == op_arith_imm || op == op_arith_var);

	ssa_shifter #(
		.WIDTH(32)
	) u_shifter (
		.data_i(src_b_i),
		.amount_i(shift_amt),
		.arith_i(shift_arith),
		.result_o(shift_res)
	);

	// sign-extended 33-bit difference, overflow on bit mismatch
	logic [32:0] diff;
	logic sub_ovf;
	assign diff = {src_a_i[31], src_a_i} - {src_b_i[31], src_b_i};
	assign sub_ovf = diff[32] ^ diff[31];

	// Output state
	logic wb_en_ff, nxt_wb_en;
	reg_idx_t wb_idx_ff, nxt_wb_idx;
	word_t wb_data_ff, nxt_wb_data;
	logic ovf_trap_ff, nxt_ovf_trap;
	logic unclaimed_ff, nxt_unclaimed;
	logic slot_used_ff, nxt_slot_used;
	logic break_group_ff, nxt_break_group;
	logic issue_alone_ff, nxt_issue_alone;
	logic ready_ff, nxt_ready;

	// Next values; data holds unless a shift or untrapped subtract issues, even to register zero, to save toggling
	always_comb begin
		nxt_wb_en = 1'b0;
		nxt_wb_idx = dest_f;
		nxt_wb_data = wb_data_ff;
		nxt_ovf_trap = 1'b0;
		nxt_unclaimed = 1'b0;
		nxt_slot_used = 1'b0;
		nxt_break_group = 1'b0;
		nxt_issue_alone = 1'b0;
		// never stalls, so the next issue may be the next cycle
		nxt_ready = 1'b1;
		if (valid_i) begin
			nxt_slot_used = 1'b1;
			case (op)
				op_arith_imm, op_arith_var, op_logic_imm, op_logic_var: begin
					nxt_wb_en = (dest_f != `SSA_REG_ZERO);
					nxt_wb_data = shift_res;
				end
				op_issue_break: begin
					// superscalar pre-6 cores split the group
					// single issue only consumes the slot
					// release 6 cores treat it as a plain no-op
					nxt_break_group = SUPERSCALAR && !RELEASE6;
					nxt_issue_alone = SUPERSCALAR && !RELEASE6;
				end
				op_sub_trap: begin
					if (sub_ovf) begin
						nxt_ovf_trap = 1'b1;
					end else begin
						nxt_wb_en = (dest_f != `SSA_REG_ZERO);
						nxt_wb_data = diff[31:0];
					end
				end
				default: nxt_unclaimed = 1'b1;
			endcase
		end
	end

	// Registered outputs, synchronous reset
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			wb_en_ff <= 1'b0;
			wb_idx_ff <= `SSA_REG_ZERO;
			wb_data_ff <= `SSA_WORD_RESET;
			ovf_trap_ff <= 1'b0;
			unclaimed_ff <= 1'b0;
			slot_used_ff <= 1'b0;
			break_group_ff <= 1'b0;
			issue_alone_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			wb_en_ff <= nxt_wb_en;
			wb_idx_ff <= nxt_wb_idx;
			wb_data_ff <= nxt_wb_data;
			ovf_trap_ff <= nxt_ovf_trap;
			unclaimed_ff <= nxt_unclaimed;
			slot_used_ff <= nxt_slot_used;
			break_group_ff <= nxt_break_group;
			issue_alone_ff <= nxt_issue_alone;
			ready_ff <= nxt_ready;
		end
	end

	assign wb_en_o = wb_en_ff;
	assign wb_idx_o = wb_idx_ff;
	assign wb_data_o = wb_data_ff;
	assign ovf_trap_o = ovf_trap_ff;
	assign unclaimed_o = unclaimed_ff;
	assign slot_used_o = slot_used_ff;
	assign break_group_o = break_group_ff;
	assign issue_alone_o = issue_alone_ff;
	assign ready_o = ready_ff;

	// Reference results for the checks, independent of the shifter
	word_t ref_ai, ref_av, ref_li, ref_lv;
	assign ref_ai = word_t'($signed(src_b_i) >>> amt_f);
	assign ref_av = word_t'($signed(src_b_i) >>> src_a_i[4:0]);
	assign ref_li = src_b_i >> amt_f;
	assign ref_lv = src_b_i >> src_a_i[4:0];

	logic is_zero_op;
	assign is_zero_op = valid_i && (opc_f == `SSA_OPC_ZERO);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	chk_arith_imm_data: assert property (
		valid_i && op == op_arith_imm && dest_f != 5'h00
		|=> wb_en_o && wb_data_o == $past(ref_ai))
		else $error("arithmetic immediate result wrong");

	chk_arith_var_decode: assert property (
		is_zero_op && func_f == 6'h07 && amt_f != 5'h00
		|=> unclaimed_o && !wb_en_o)
		else $error("variable arithmetic with stray bits claimed");

	chk_arith_var_data: assert property (
		valid_i && op == op_arith_var && dest_f != 5'h00
		|=> wb_en_o && wb_data_o == $past(ref_av))
		else $error("variable arithmetic result wrong");

	chk_logic_imm_decode: assert property (
		is_zero_op && func_f == 6'h02 && src_a_f != 5'h00
		|=> unclaimed_o && !wb_en_o)
		else $error("immediate logical with stray bits claimed");

	chk_logic_imm_data: assert property (
		valid_i && op == op_logic_imm && dest_f != 5'h00
		|=> wb_en_o && wb_data_o == $past(ref_li)
			&& wb_idx_o == $past(dest_f))
		else $error("immediate logical result wrong");

	chk_logic_var_decode: assert property (
		is_zero_op && func_f == 6'h06 && amt_f != 5'h00
		|=> unclaimed_o && !wb_en_o)
		else $error("variable logical with stray bits claimed");

	chk_logic_var_data: assert property (
		valid_i && op == op_logic_var && dest_f != 5'h00
		|=> wb_en_o && wb_data_o == $past(ref_lv))
		else $error("variable logical result wrong");

	chk_break_no_write: assert property (
		valid_i && instr_i == 32'h00000040
		|=> !wb_en_o && !ovf_trap_o && slot_used_o && $stable(wb_data_o))
		else $error("issue-break changed state");

	chk_break_alone: assert property (
		valid_i && instr_i == 32'h00000040 && SUPERSCALAR && !RELEASE6
		|=> break_group_o && issue_alone_o)
		else $error("issue-break did not split group");

	chk_single_plain: assert property (
		!SUPERSCALAR && valid_i |=> !break_group_o && !issue_alone_o)
		else $error("single issue core split a group");

	chk_rel6_plain: assert property (
		RELEASE6 && valid_i |=> !break_group_o && !issue_alone_o)
		else $error("release 6 issue-break not plain");

	chk_break_no_stall: assert property (
		valid_i && op == op_issue_break |=> ready_o ##1 ready_o)
		else $error("issue-break stalled the next issue");

	chk_sub_decode: assert property (
		is_zero_op && func_f == 6'h22 && amt_f != 5'h00
		|=> unclaimed_o && !ovf_trap_o)
		else $error("subtract with stray bits claimed");

	chk_sub_overflow: assert property (
		valid_i && op == op_sub_trap && sub_ovf
		|=> ovf_trap_o && !wb_en_o && $stable(wb_data_o))
		else $error("overflow did not trap cleanly");

	chk_sub_data: assert property (
		valid_i && op == op_sub_trap && !sub_ovf && dest_f != 5'h00
		|=> wb_en_o && !ovf_trap_o
			&& wb_data_o == $past(src_a_i) - $past(src_b_i))
		else $error("subtract result wrong");

	chk_zero_dest: assert property (
		valid_i && dest_f == 5'h00 |=> !wb_en_o)
		else $error("write to register zero");

endmodule

// ---- rtl/ssa_map.svh ----
/*
 * Instruction field positions and encodings for the shift and
 * trapping subtract execution slice.
 * Assumes a 32-bit instruction word as presented by the issue stage.
 */
`ifndef SSA_MAP_SVH
`define SSA_MAP_SVH

// Field positions
`define SSA_OPC_HI 31
`define SSA_OPC_LO 26
`define SSA_SRC_A_HI 25
`define SSA_SRC_A_LO 21
`define SSA_SRC_B_HI 20
`define SSA_SRC_B_LO 16
`define SSA_DEST_HI 15
`define SSA_DEST_LO 11
`define SSA_AMT_HI 10
`define SSA_AMT_LO 6
`define SSA_FUNC_HI 5
`define SSA_FUNC_LO 0

// Encodings
`define SSA_OPC_ZERO 6'h00
`define SSA_FN_ARITH_IMM 6'h03
`define SSA_FN_ARITH_VAR 6'h07
`define SSA_FN_LOGIC_IMM 6'h02
`define SSA_FN_LOGIC_VAR 6'h06
`define SSA_FN_SUB_TRAP 6'h22
`define SSA_BREAK_WORD 32'h00000040
`define SSA_REG_ZERO 5'h00
`define SSA_WORD_RESET 32'h00000000

`endif

// ---- rtl/ssa_pkg.sv ----
/*
 * Types shared by the shift and trapping subtract execution slice.
 * Assumes ssa_map.svh supplies the numeric encodings.
 */
package ssa_pkg;

	typedef logic [31:0] word_t;
	typedef logic [4:0] reg_idx_t;

	// Decoded operation class
	typedef enum logic [2:0] {
		op_none,
		op_arith_imm,
		op_arith_var,
		op_logic_imm,
		op_logic_var,
		op_issue_break,
		op_sub_trap
	} op_e;

endpackage

// ---- rtl/ssa_shifter.sv ----
/*
 * Logarithmic right shifter, one stage per bit of the amount.
 * Assumes a purely combinational use inside the execution slice.
 */
`timescale 1ns/1ps

module ssa_shifter #(
	parameter int WIDTH = 32
) (
	// Operand and control
	input wire logic [WIDTH-1:0] data_i,
	input wire logic [$clog2(WIDTH)-1:0] amount_i,
	input wire logic arith_i,
	// Result
	output logic [WIDTH-1:0] result_o
);

	localparam int STAGES = $clog2(WIDTH);

	logic [WIDTH-1:0] stage [0:STAGES];
	logic fill;

	// Sign fill only for the arithmetic form
	assign fill = arith_i & data_i[WIDTH-1];
	assign stage[0] = data_i;

	// One stage per amount bit keeps depth at log2 of the width
	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : g_stage
			localparam int SH = 1 << g;
			assign stage[g+1] = amount_i[g] ?
				{{SH{fill}}, stage[g][WIDTH-1:SH]} : stage[g];
		end
	endgenerate

	assign result_o = stage[STAGES];

endmodule

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench for the shift and trapping subtract slice.
 * Assumes the slice answers exactly one cycle after each issue.
 */
`timescale 1ns/1ps
`include "ssa_map.svh"
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("Error at %0t: got %0h expected %0h", $time, g, e); \
	end \
end

module tb_top;
	import ssa_pkg::*;

	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic valid_i = 1'b0;
	word_t instr_i = '0;
	word_t src_a_i = '0;
	word_t src_b_i = '0;
	logic wb_en_o, ovf_trap_o, unclaimed_o, slot_used_o;
	logic break_group_o, issue_alone_o, ready_o, r6_brk, r6_slot;
	logic s1_brk, s1_alone, s1_slot;
	logic [4:0] wb_idx_o;
	word_t wb_data_o, r6_data, exp_data, ins, r;
	logic e_en, e_ovf, e_unc, e_slot, e_brk;
	logic [4:0] e_idx;
	int fails = 0;
	int tests_run = 0;
	int seed = 32'h6878;
	logic [5:0] fns [6] = '{`SSA_FN_ARITH_IMM, `SSA_FN_LOGIC_IMM,
		`SSA_FN_ARITH_VAR, `SSA_FN_LOGIC_VAR, `SSA_FN_SUB_TRAP, 6'h00};

	shift_subtract_alu dut (.clock_i(clock_i), .resetn_i(resetn_i),
		.valid_i(valid_i), .instr_i(instr_i), .src_a_i(src_a_i),
		.src_b_i(src_b_i), .wb_en_o(wb_en_o), .wb_idx_o(wb_idx_o),
		.wb_data_o(wb_data_o), .ovf_trap_o(ovf_trap_o),
		.unclaimed_o(unclaimed_o), .slot_used_o(slot_used_o),
		.break_group_o(break_group_o), .issue_alone_o(issue_alone_o),
		.ready_o(ready_o));

	// Later-release flavour: issue-break must be a plain no-op there
	shift_subtract_alu #(.RELEASE6(1'b1)) dut_r6 (.clock_i(clock_i),
		.resetn_i(resetn_i), .valid_i(valid_i), .instr_i(instr_i),
		.src_a_i(src_a_i), .src_b_i(src_b_i), .wb_en_o(), .wb_idx_o(),
		.wb_data_o(r6_data), .ovf_trap_o(), .unclaimed_o(),
		.slot_used_o(r6_slot), .break_group_o(r6_brk),
		.issue_alone_o(), .ready_o());

	// Single-issue flavour: issue-break only takes its slot
	shift_subtract_alu #(.SUPERSCALAR(1'b0)) dut_s1 (.clock_i(clock_i),
		.resetn_i(resetn_i), .valid_i(valid_i), .instr_i(instr_i),
		.src_a_i(src_a_i), .src_b_i(src_b_i), .wb_en_o(), .wb_idx_o(),
		.wb_data_o(), .ovf_trap_o(), .unclaimed_o(),
		.slot_used_o(s1_slot), .break_group_o(s1_brk),
		.issue_alone_o(s1_alone), .ready_o());

	// Free-running core clock, 50 ns period
	always #25 clock_i = ~clock_i;

	function automatic word_t mk(logic [4:0] s, t, d, amt, logic [5:0] fn);
		return {6'h00, s, t, d, amt, fn};
	endfunction

	// Reference decode; data expectation moves on any shift or untrapped subtract, even to register zero
	task automatic predict(logic v, word_t i, word_t a, word_t b);
		logic [32:0] df;
		logic wr;
		df = {a[31], a} - {b[31], b};
		wr = 1'b0;
		{e_unc, e_ovf, e_brk} = 3'b000;
		e_slot = v;
		e_idx = i[15:11];
		if (!v) begin
		end else if (i == `SSA_BREAK_WORD) begin
			e_brk = 1'b1;
		end else if (i[31:26] != 6'h00) begin
			e_unc = 1'b1;
		end else if (i[5:1] == 5'h01 && i[25:21] == 5'h00) begin
			wr = 1'b1;
			r = i[0] ? word_t'($signed(b) >>> i[10:6]) : b >> i[10:6];
		end else if (i[5:1] == 5'h03 && i[10:6] == 5'h00) begin
			wr = 1'b1;
			r = i[0] ? word_t'($signed(b) >>> a[4:0]) : b >> a[4:0];
		end else if (i[5:0] == `SSA_FN_SUB_TRAP && i[10:6] == 5'h00) begin
			e_ovf = df[32] != df[31];
			wr = !e_ovf;
			r = df[31:0];
		end else begin
			e_unc = 1'b1;
		end
		e_en = wr && e_idx != 5'h00;
		if (wr) exp_data = r;
	endtask

	// Check the previous issue's answer, then present the next one
	task automatic step(logic v, word_t i, word_t a, word_t b);
		@(negedge clock_i);
		`CHK(wb_en_o, e_en)
		if (e_en) `CHK(wb_idx_o, e_idx)
		`CHK(wb_data_o, exp_data)
		`CHK(ovf_trap_o, e_ovf)
		`CHK(unclaimed_o, e_unc)
		`CHK(slot_used_o, e_slot)
		`CHK(break_group_o, e_brk)
		`CHK(issue_alone_o, e_brk)
		`CHK(ready_o, 1'b1)
		`CHK(r6_brk, 1'b0)
		`CHK(r6_slot, e_slot)
		`CHK(r6_data, exp_data)
		`CHK(s1_brk | s1_alone, 1'b0)
		`CHK(s1_slot, e_slot)
		{valid_i, instr_i, src_a_i, src_b_i} = {v, i, a, b};
		predict(v, i, a, b);
	endtask

	task automatic do_reset(int n);
		@(negedge clock_i);
		resetn_i = 1'b0;
		valid_i = 1'b0;
		repeat (n) @(negedge clock_i);
		`CHK(ready_o, 1'b0)
		`CHK(wb_data_o, 32'h00000000)
		resetn_i = 1'b1;
		exp_data = '0;
		predict(1'b0, '0, '0, '0);
	endtask

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Corner cases first, then seeded random traffic with idle gaps
	initial begin
		do_reset(12);
		step(1, mk(0, 2, 3, 31, 6'h03), 0, 32'h80000000);
		step(1, mk(0, 2, 4, 31, 6'h02), 0, 32'h80000000);
		step(1, mk(1, 2, 5, 0, 6'h07), 32'hFFFFFFE4, 32'h800000F0);
		step(1, mk(1, 2, 6, 0, 6'h06), 32'hFFFFFFFF, 32'h800000F0);
		step(1, mk(1, 2, 7, 0, 6'h22), 32'h80000000, 1);
		step(1, mk(1, 2, 7, 0, 6'h22), 32'h7FFFFFFF, 32'hFFFFFFFF);
		step(1, mk(1, 2, 8, 0, 6'h22), 32'hFFFFFFFF, 32'h7FFFFFFF);
		step(1, mk(1, 2, 0, 0, 6'h22), 5, 3);
		step(1, `SSA_BREAK_WORD, 1, 2);
		step(1, `SSA_BREAK_WORD, 3, 4);
		step(1, mk(1, 2, 9, 4, 6'h02), 0, 32'hF0);
		step(1, mk(0, 2, 9, 4, 6'h03), 0, 32'hF0);
		step(1, mk(1, 2, 9, 1, 6'h06), 0, 32'hF0);
		step(1, mk(1, 2, 9, 16, 6'h07), 0, 32'hF0);
		step(1, mk(1, 2, 9, 16, 6'h22), 7, 1);
		// Idle issue so the last corner case is checked before reset
		step(0, '0, '0, '0);
		do_reset(2);
		for (int k = 0; k < 600; k++) begin
			r = $random(seed);
			ins = $random(seed);
			ins[5:0] = fns[r[7:0] % 6];
			if (r[11:8] != 4'h0) ins[31:26] = 6'h00;
			if (r[15:12] != 4'h0 && ins[5:1] == 5'h01) ins[25:21] = 5'h00;
			if (r[15:12] != 4'h0 && ins[5:1] != 5'h01) ins[10:6] = 5'h00;
			step(r[19:16] != 4'h0, ins, $random(seed), $random(seed));
		end
		step(0, '0, '0, '0);
		finish_test();
	end

	// Cut a hang well past the expected run of about 650 cycles
	initial begin
		repeat (5000) @(posedge clock_i);
		fails++;
		finish_test();
	end
endmodule
